// [logic/pscr_defines.svh]
`ifndef PSCR_DEFINES_SVH
`define PSCR_DEFINES_SVH

// Register addresses on the serial register port
`define PSCR_ADDR_FLAGS 8'h01
`define PSCR_ADDR_MASK 8'h02
`define PSCR_ADDR_ENABLE 8'h03
`define PSCR_ADDR_MODE 8'h04

// Values loaded on undervoltage lockout; PSCR_UNMAPPED is the value read from an unmapped address
`define PSCR_RST_MASK 8'hC0
`define PSCR_RST_ENABLE 8'hFF
`define PSCR_RST_MODE 8'hB0
`define PSCR_UNMAPPED 8'hFF

// Implemented bit sets
`define PSCR_MASK_IMPL 8'hFF
`define PSCR_ENABLE_IMPL 8'h3E
`define PSCR_MODE_IMPL 8'hFF

// Supply enable bit positions
`define PSCR_EN_BUCK1 5
`define PSCR_EN_BUCK2 4
`define PSCR_EN_BUCK3 3
`define PSCR_EN_LREG2 2
`define PSCR_EN_LREG1 1

// Converter mode field positions
`define PSCR_MODE_PH2_HI 7
`define PSCR_MODE_PH2_LO 6
`define PSCR_MODE_PH3_HI 5
`define PSCR_MODE_PH3_LO 4
`define PSCR_MODE_RIPPLE 3
`define PSCR_MODE_FF_BUCK2 2
`define PSCR_MODE_FF_BUCK1 1
`define PSCR_MODE_FF_BUCK3 0

// Status flag positions
`define PSCR_FLAG_LREG1 1

`endif

// [logic/pscr_pkg.sv]
`default_nettype none
package pscr_pkg;

	// Phase delay codes relative to buck1
	typedef enum logic [1:0] {
		PSCR_PH_ZERO = 2'b00,
		PSCR_PH_QUARTER = 2'b01,
		PSCR_PH_HALF = 2'b10,
		PSCR_PH_3QUARTER = 2'b11
	} pscr_phase_e;

	// Per-supply enables and modes toward the analog section
	typedef struct packed {
		logic buck1;
		logic buck2;
		logic buck3;
		logic lreg2;
		logic lreg1;
	} pscr_supply_s;

	typedef struct packed {
		pscr_phase_e buck2_phase;
		pscr_phase_e buck3_phase;
		logic low_ripple;
		logic buck2_fixed;
		logic buck1_fixed;
		logic buck3_fixed;
	} pscr_mode_s;

	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pscr_req_s;

endpackage
`default_nettype wire

// [logic/pscr_regs.sv]
`timescale 1ns/100ps
`include "pscr_defines.svh"
`default_nettype none
module pscr_regs
	import pscr_pkg::*;
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic undervoltage_lockout_i,
	input wire pscr_req_s req_i,
	output logic [7:0] rdata_o,
	input wire logic buck1_enable_pin_i,
	input wire logic buck2_enable_pin_i,
	input wire logic buck3_enable_pin_i,
	input wire logic linear_reg_enable_pin_i,
	input wire logic [7:1] fault_raw_i,
	output var pscr_supply_s supply_on_o,
	output var pscr_mode_s mode_o,
	output logic [7:0] power_fault_flags_o,
	output logic fault_alert_pin_n_o
);

	// Pins are asynchronous to clk_i
	logic [3:0] pin_s1_ff, pin_s2_ff;
	logic [7:1] raw_s1_ff, raw_s2_ff;
	logic undervoltage_lockout_s1_ff, undervoltage_lockout_s2_ff;

	// Two-stage synchronisers; first stage read only by the second
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_s1_ff <= 4'h0;
			pin_s2_ff <= 4'h0;
			raw_s1_ff <= 7'h00;
			raw_s2_ff <= 7'h00;
			undervoltage_lockout_s1_ff <= 1'b1;
			undervoltage_lockout_s2_ff <= 1'b1;
		end else begin
			pin_s1_ff <= {buck1_enable_pin_i, buck2_enable_pin_i, buck3_enable_pin_i, linear_reg_enable_pin_i};
			pin_s2_ff <= pin_s1_ff;
			raw_s1_ff <= fault_raw_i;
			raw_s2_ff <= raw_s1_ff;
			undervoltage_lockout_s1_ff <= undervoltage_lockout_i;
			undervoltage_lockout_s2_ff <= undervoltage_lockout_s1_ff;
		end
	end

	// Pin paired with each enable bit, indexed by bit position
	logic [7:0] bit_pin;
	assign bit_pin = {2'b11, pin_s2_ff[3], pin_s2_ff[2], pin_s2_ff[1], pin_s2_ff[0], pin_s2_ff[0], 1'b1};

	logic [7:0] mask_ff, nxt_mask;
	logic [7:0] enable_ff, nxt_enable;
	logic [7:0] mode_ff, nxt_mode;
	logic [7:0] block_ff, nxt_block;
	logic [7:0] rdata_ff, nxt_rdata;
	logic [7:0] flags;

	// Write merge keeping unimplemented bits at default
	function automatic logic [7:0] merge(input logic [7:0] wd, input logic [7:0] impl, input logic [7:0] dflt);
		merge = (wd & impl) | (dflt & ~impl);
	endfunction

	// Supply disabled makes its flag read zero
	assign flags = {raw_s2_ff[7:6], raw_s2_ff[5:1] & enable_ff[5:1] & bit_pin[5:1], 1'b0};

	// Next register values; lockout dominates, then pin-low reload
	always_comb begin
		nxt_mask = mask_ff;
		nxt_enable = enable_ff;
		nxt_mode = mode_ff;
		nxt_block = block_ff & flags; // Cleared flag unblocks for next event
		nxt_rdata = rdata_ff;
		if (req_i.wr && req_i.addr == `PSCR_ADDR_MASK)
			nxt_mask = merge(req_i.wdata, `PSCR_MASK_IMPL, `PSCR_RST_MASK);
		if (req_i.wr && req_i.addr == `PSCR_ADDR_ENABLE)
			nxt_enable = merge(req_i.wdata, `PSCR_ENABLE_IMPL, `PSCR_RST_ENABLE);
		if (req_i.wr && req_i.addr == `PSCR_ADDR_MODE)
			nxt_mode = merge(req_i.wdata, `PSCR_MODE_IMPL, `PSCR_RST_MODE);
		// Pin low forces its bit back to default, beating a write
		nxt_enable = (nxt_enable & bit_pin) | (`PSCR_RST_ENABLE & ~bit_pin);
		if (req_i.rd) begin
			unique case (req_i.addr)
				`PSCR_ADDR_FLAGS: begin
					nxt_rdata = flags;
					nxt_block = block_ff | flags;
				end
				`PSCR_ADDR_MASK: nxt_rdata = mask_ff;
				`PSCR_ADDR_ENABLE: nxt_rdata = enable_ff;
				`PSCR_ADDR_MODE: nxt_rdata = mode_ff;
				default: nxt_rdata = `PSCR_UNMAPPED;
			endcase
		end
		if (undervoltage_lockout_s2_ff) begin
			nxt_mask = `PSCR_RST_MASK;
			nxt_enable = `PSCR_RST_ENABLE;
			nxt_mode = `PSCR_RST_MODE;
			nxt_block = 8'h00;
		end
	end

	// Register state
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mask_ff <= `PSCR_RST_MASK;
			enable_ff <= `PSCR_RST_ENABLE;
			mode_ff <= `PSCR_RST_MODE;
			block_ff <= 8'h00;
			rdata_ff <= 8'h00;
		end else begin
			mask_ff <= nxt_mask;
			enable_ff <= nxt_enable;
			mode_ff <= nxt_mode;
			block_ff <= nxt_block;
			rdata_ff <= nxt_rdata;
		end
	end

	// Outputs; alert is the open-drain OR of unmasked, unblocked fault flags
	logic alert_ff, nxt_alert;
	always_comb begin
		nxt_alert = |(flags & ~mask_ff & ~block_ff);
	end

	// Alert register; inactive while in reset
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			alert_ff <= 1'b0;
		else
			alert_ff <= nxt_alert;
	end
	assign fault_alert_pin_n_o = ~alert_ff;
	assign rdata_o = rdata_ff;
	assign power_fault_flags_o = flags;

	// Supply gating: pin and bit both required
	assign supply_on_o.buck1 = bit_pin[`PSCR_EN_BUCK1] & enable_ff[`PSCR_EN_BUCK1];
	assign supply_on_o.buck2 = bit_pin[`PSCR_EN_BUCK2] & enable_ff[`PSCR_EN_BUCK2];
	assign supply_on_o.buck3 = bit_pin[`PSCR_EN_BUCK3] & enable_ff[`PSCR_EN_BUCK3];
	assign supply_on_o.lreg2 = bit_pin[`PSCR_EN_LREG2] & enable_ff[`PSCR_EN_LREG2];
	assign supply_on_o.lreg1 = bit_pin[`PSCR_EN_LREG1] & enable_ff[`PSCR_EN_LREG1];

	// Converter mode fields
	assign mode_o.buck2_phase = pscr_phase_e'(mode_ff[`PSCR_MODE_PH2_HI:`PSCR_MODE_PH2_LO]);
	assign mode_o.buck3_phase = pscr_phase_e'(mode_ff[`PSCR_MODE_PH3_HI:`PSCR_MODE_PH3_LO]);
	assign mode_o.low_ripple = mode_ff[`PSCR_MODE_RIPPLE];
	assign mode_o.buck2_fixed = mode_ff[`PSCR_MODE_FF_BUCK2];
	assign mode_o.buck1_fixed = mode_ff[`PSCR_MODE_FF_BUCK1];
	assign mode_o.buck3_fixed = mode_ff[`PSCR_MODE_FF_BUCK3];

	a_mask_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.wr && req_i.addr == `PSCR_ADDR_MASK && !undervoltage_lockout_s2_ff |=> mask_ff == $past(req_i.wdata))
		else $error("mask write lost");
	a_undervoltage_lockout_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
		undervoltage_lockout_s2_ff |=> mask_ff == `PSCR_RST_MASK && enable_ff == `PSCR_RST_ENABLE && mode_ff == `PSCR_RST_MODE)
		else $error("lockout defaults wrong");
	a_pin_low_reload: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!pin_s2_ff[3] |=> enable_ff[5])
		else $error("enable bit not reloaded");
	a_supply_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
		supply_on_o.buck2 == (pin_s2_ff[2] && enable_ff[4]))
		else $error("buck2 gating wrong");
	a_unmapped_read: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.rd && req_i.addr > `PSCR_ADDR_MODE |=> rdata_o == `PSCR_UNMAPPED)
		else $error("unmapped read not FF");
	a_read_blocks: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.rd && req_i.addr == `PSCR_ADDR_FLAGS && !undervoltage_lockout_s2_ff ##1 flags == $past(flags)
		|=> fault_alert_pin_n_o)
		else $error("read flags still alert");
	a_masked_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
		(mask_ff == 8'hFF) |=> fault_alert_pin_n_o)
		else $error("masked flag reached alert");
	a_alert_assert: assert property (@(posedge clk_i) disable iff (!rstn_i)
		|(flags & ~mask_ff & ~block_ff) |=> !fault_alert_pin_n_o)
		else $error("alert not asserted");
	a_disabled_flag: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!supply_on_o.lreg1 |-> !power_fault_flags_o[`PSCR_FLAG_LREG1])
		else $error("disabled rail flag set");
	a_ripple_bit: assert property (@(posedge clk_i) disable iff (!rstn_i)
		req_i.wr && req_i.addr == `PSCR_ADDR_MODE && !undervoltage_lockout_s2_ff |=> mode_o.low_ripple == $past(req_i.wdata[3]))
		else $error("ripple mode not written");

endmodule
`default_nettype wire

// [dv/pscr_host.sv]
`timescale 1ns/100ps
`default_nettype none
// Host model on the register port, one request per task call
module pscr_host
	import pscr_pkg::*;
(
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output var pscr_req_s req_o
);
	// Idle port until the first call
	initial begin
		req_o = '0;
	end

	// Strobe held for exactly the taking edge; released bytes are inverted so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#2;
		req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
		#2;
		req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask

	// Read data is registered, so it is taken once the taking edge has landed
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#2;
		req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_i);
		#2;
		d = rdata_i;
		req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
	endtask
endmodule
`default_nettype wire

// [dv/pscr_regs_tb_top.sv]
`timescale 1ns/100ps
`include "pscr_defines.svh"
`default_nettype none
module pscr_regs_tb_top
	import pscr_pkg::*;
;
	logic clk_i, rstn_i, undervoltage_lockout_i, alert_n;
	logic [3:0] pin;
	logic [7:1] raw;
	logic [7:0] rdata, flags;
	pscr_req_s req;
	pscr_supply_s sup;
	pscr_mode_s mode;
	int fails, checks_done;

	pscr_regs pscr_regs_inst (.clk_i(clk_i), .rstn_i(rstn_i), .undervoltage_lockout_i(undervoltage_lockout_i), .req_i(req), .rdata_o(rdata),
		.buck1_enable_pin_i(pin[3]), .buck2_enable_pin_i(pin[2]), .buck3_enable_pin_i(pin[1]),
		.linear_reg_enable_pin_i(pin[0]), .fault_raw_i(raw), .supply_on_o(sup), .mode_o(mode),
		.power_fault_flags_o(flags), .fault_alert_pin_n_o(alert_n));
	pscr_host pscr_host_inst (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));

	// 40 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		pscr_host_inst.rd(a, d);
		check_byte(d, e);
	endtask

	// Two sync stages, alert stage, two spare
	task automatic settle;
		repeat (5) @(posedge clk_i);
		#2;
	endtask

	task automatic sc_defaults;
		rd_chk(`PSCR_ADDR_MASK, 8'hC0);
		rd_chk(`PSCR_ADDR_ENABLE, 8'hFF);
		rd_chk(`PSCR_ADDR_MODE, 8'hB0);
		check_byte(mode, 8'hB0);
		check_byte({3'b000, sup}, 8'h1F);
		rd_chk(8'h00, 8'hFF);
		rd_chk(8'h05, 8'hFF);
	endtask

	// Every phase code in both fields, each of mode bits 3 to 0 alone
	task automatic sc_mode;
		logic [7:0] v[8] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'h08, 8'h04, 8'h02, 8'h01};
		foreach (v[i]) begin
			pscr_host_inst.wr(`PSCR_ADDR_MODE, v[i]);
			check_byte(mode, v[i]);
			rd_chk(`PSCR_ADDR_MODE, v[i]);
		end
	endtask

	task automatic sc_enable;
		for (int i = 1; i <= 5; i++) begin
			pscr_host_inst.wr(`PSCR_ADDR_ENABLE, 8'h01 << i);
			check_byte({3'b000, sup}, 8'h01 << (i - 1));
			rd_chk(`PSCR_ADDR_ENABLE, 8'hC1 | (8'h01 << i));
		end
		pin[2] = 1'b0;
		settle();
		pscr_host_inst.wr(`PSCR_ADDR_ENABLE, 8'h00);
		rd_chk(`PSCR_ADDR_ENABLE, 8'hD1);
		check_byte({3'b000, sup}, 8'h00);
		pin[2] = 1'b1;
		settle();
		check_byte({3'b000, sup}, 8'h08);
		pscr_host_inst.wr(`PSCR_ADDR_ENABLE, 8'hFF);
	endtask

	task automatic sc_faults;
		pscr_host_inst.wr(`PSCR_ADDR_FLAGS, 8'hFF);
		pscr_host_inst.wr(`PSCR_ADDR_MASK, 8'h00);
		rd_chk(`PSCR_ADDR_FLAGS, 8'h00);
		raw[1] = 1'b1;
		settle();
		check_byte(flags, 8'h02);
		check_byte({7'd0, alert_n}, 8'h00);
		pscr_host_inst.wr(`PSCR_ADDR_MASK, 8'h02);
		settle();
		check_byte({7'd0, alert_n}, 8'h01);
		pscr_host_inst.wr(`PSCR_ADDR_MASK, 8'h00);
		settle();
		check_byte({7'd0, alert_n}, 8'h00);
		rd_chk(`PSCR_ADDR_FLAGS, 8'h02);
		settle();
		check_byte({7'd0, alert_n}, 8'h01);
		raw[5] = 1'b1;
		settle();
		check_byte({7'd0, alert_n}, 8'h00);
		pscr_host_inst.wr(`PSCR_ADDR_MASK, 8'hFF);
		settle();
		check_byte({7'd0, alert_n}, 8'h01);
		pscr_host_inst.wr(`PSCR_ADDR_MASK, 8'h00);
		pscr_host_inst.wr(`PSCR_ADDR_ENABLE, 8'hFD);
		settle();
		check_byte(flags, 8'h20);
		raw = '0;
		pscr_host_inst.wr(`PSCR_ADDR_ENABLE, 8'hFF);
		settle();
		check_byte({7'd0, alert_n}, 8'h01);
	endtask

	// Lockout must reload every register whatever was written
	task automatic sc_undervoltage_lockout;
		pscr_host_inst.wr(`PSCR_ADDR_MASK, 8'h3E);
		pscr_host_inst.wr(`PSCR_ADDR_MODE, 8'h00);
		pscr_host_inst.wr(`PSCR_ADDR_ENABLE, 8'h00);
		undervoltage_lockout_i = 1'b1;
		settle();
		undervoltage_lockout_i = 1'b0;
		settle();
		sc_defaults();
	endtask

	// Mid-run reset must restore the same defaults as lockout
	task automatic sc_reset;
		pscr_host_inst.wr(`PSCR_ADDR_MASK, 8'h3E);
		rstn_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#2;
		rstn_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#2;
		sc_defaults();
	endtask

	task automatic wrap_up;
		$display("checks=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge clk_i);
		fails++;
		wrap_up();
	end

	// Main sequence
	initial begin
		rstn_i = 1'b0;
		undervoltage_lockout_i = 1'b0;
		pin = 4'hF;
		raw = '0;
		fails = 0;
		checks_done = 0;
		repeat (20) @(posedge clk_i);
		#2;
		rstn_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#2;
		sc_defaults();
		sc_mode();
		sc_enable();
		sc_faults();
		sc_undervoltage_lockout();
		sc_reset();
		wrap_up();
	end
endmodule
`default_nettype wire
